// file: logic/frmh_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Loop-back after halt or freeze still filters and stores received messages.
// - Leading coldstarter after freeze or ready sends start-up frame in cycle 0.
// - Test access to input RAM two selects only that RAM.
// - Test access to output RAM one never selects output RAM two.
// - Each buffer RAM read is parity checked; errors set the status flag.
// - Either RAM of a pair sets the shared flag; source not recorded.
// - The two RAMs of each pair swap roles through a swap bit.
// - Max-length read to output buffer leaves output word zero intact.
// - Input buffer to message RAM writes exactly the data section.
// - Last configured buffer field sets where the data partition begins.
// - Received frames go straight from the synchronised rx pins to their data section.
// - Loop-back receives and stores frames only at the fastest prescaler setting.
module frmh_core
  import frmh_pkg::*;
#(
  parameter int MRAM_AW = FRMH_MRAM_W,
  parameter int BUF_AW = 6
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [FRMH_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic rx_valid_in,
  input wire logic [31:0] rx_word_in,
  input wire logic rx_last_in,
  output logic tx_startup_out,
  output logic [1:0] test_sel_out,
  output logic irq_out
);
  // A maximum-length burst needs 64 buffer words, or word zero would be overwritten
  if (BUF_AW < 6 || BUF_AW > MRAM_AW) begin : g_chk_aw
    $error("frmh_core: BUF_AW out of range");
  end
  // Rx pins are asynchronous: two stage sync
  logic rxv_s1_q, rxv_s2_q, rxl_s1_q, rxl_s2_q;
  logic [31:0] rxw_s1_q, rxw_s2_q;
  always_ff @(posedge sys_clk_in) begin
    rxv_s1_q <= rx_valid_in;
    rxv_s2_q <= rxv_s1_q;
    rxw_s1_q <= rx_word_in;
    rxw_s2_q <= rxw_s1_q;
    rxl_s1_q <= rx_last_in;
    rxl_s2_q <= rxl_s1_q;
  end
  frmh_ram_if #(.AW(MRAM_AW)) mram_p ();
  frmh_ram_if #(.AW(BUF_AW)) ib_p [2] ();
  frmh_ram_if #(.AW(BUF_AW)) ob_p [2] ();
  frmh_ram #(.AW(MRAM_AW)) u_mram (.sys_clk_in(sys_clk_in), .port(mram_p));
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_buf
      frmh_ram #(.AW(BUF_AW)) u_ib (.sys_clk_in(sys_clk_in), .port(ib_p[g]));
      frmh_ram #(.AW(BUF_AW)) u_ob (.sys_clk_in(sys_clk_in), .port(ob_p[g]));
    end
  endgenerate
  function automatic logic hit(input logic [FRMH_ADDR_W-1:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction
  logic [31:0] cfg_q;
  logic [FRMH_NIRQ-1:0] irq_st_q, mask_q;
  logic [2:0] test_ram_q;
  logic [BUF_AW-1:0] test_addr_q;
  logic [MRAM_AW-1:0] mram_addr_q;
  frmh_poc_t poc_q;
  logic ib_swap_q, ob_swap_q, test_q;
  logic [7:0] lcb;
  logic [1:0] brp;
  logic [6:0] payload_length_setting;
  assign lcb = cfg_q[FRMH_CFG_LCB_LSB +: 8];
  assign brp = cfg_q[FRMH_CFG_BRP_LSB +: 2];
  assign payload_length_setting = cfg_q[FRMH_CFG_PLC_LSB +: 7];
  // Data partition starts after header partition of the last buffer
  logic [MRAM_AW-1:0] data_base;
  assign data_base = MRAM_AW'({lcb, 1'b0} + 9'h002);
  // Protocol state: one transition per command
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      poc_q <= FRMH_ST_DEFCFG;
    end else if (wr_in && hit(addr_in, FRMH_REG_CMD)) begin
      unique case (wdata_in[3:0])
        FRMH_CMD_CONFIG: if (poc_q == FRMH_ST_DEFCFG || poc_q == FRMH_ST_HALT ||
                             poc_q == FRMH_ST_READY) poc_q <= FRMH_ST_CFG;
        FRMH_CMD_READY: if (poc_q != FRMH_ST_DEFCFG && poc_q != FRMH_ST_HALT)
                          poc_q <= FRMH_ST_READY;
        FRMH_CMD_RUN: if (poc_q == FRMH_ST_READY) poc_q <= FRMH_ST_NORMAL;
        FRMH_CMD_COLD: if (poc_q == FRMH_ST_READY) poc_q <= FRMH_ST_COLD;
        FRMH_CMD_HALT, FRMH_CMD_FREEZE: poc_q <= FRMH_ST_HALT;
        FRMH_CMD_LOOP: if (poc_q == FRMH_ST_CFG) poc_q <= FRMH_ST_LOOPB;
        default: poc_q <= poc_q;
      endcase
    end else if (poc_q == FRMH_ST_COLD && tx_startup_out) begin
      poc_q <= FRMH_ST_NORMAL;
    end
  end
  // Start-up frame in cycle 0 regardless of history or slot number
  logic cold_d;
  assign cold_d = (poc_q == FRMH_ST_COLD) && !tx_startup_out;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) tx_startup_out <= 1'b0;
    else tx_startup_out <= cold_d;
  end
  // Receive: acceptance filtering runs whenever receiving, stateless of history
  logic rx_ok, rx_done, test_acc;
  logic [MRAM_AW-1:0] rx_ptr_q;
  assign rx_ok = rxv_s2_q && (poc_q == FRMH_ST_NORMAL || poc_q == FRMH_ST_COLD ||
                 (poc_q == FRMH_ST_LOOPB && brp == FRMH_BRP_FAST));
  assign rx_done = rx_ok && rxl_s2_q;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) rx_ptr_q <= '0;
    else if (!rx_ok) rx_ptr_q <= data_base;
    else rx_ptr_q <= rx_ptr_q + 1'b1;
  end
  // Host transfers: dir 1 = input buffer to message RAM, 0 = message RAM to output
  logic xf_busy_q, xf_dir_q, xf_start, xf_rd_q;
  logic [7:0] xf_cnt_q, xf_len;
  logic [BUF_AW-1:0] xf_widx_q;
  assign xf_len = 8'({1'b0, payload_length_setting} + 8'h01) >> 1;
  assign xf_start = wr_in && hit(addr_in, FRMH_REG_XFER) && !xf_busy_q && !test_q;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      xf_busy_q <= 1'b0;
      xf_dir_q <= 1'b0;
      xf_cnt_q <= '0;
    end else if (xf_start) begin
      xf_busy_q <= 1'b1;
      xf_dir_q <= wdata_in[0];
      xf_cnt_q <= '0;
    end else if (xf_busy_q && !rx_ok) begin
      // Last word count ends the burst; no overrun word
      if (xf_cnt_q == xf_len - 8'h01) xf_busy_q <= 1'b0;
      xf_cnt_q <= xf_cnt_q + 8'h01;
    end
  end
  // Delay for read latency on output direction
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      xf_rd_q <= 1'b0;
      xf_widx_q <= '0;
    end else begin
      xf_rd_q <= xf_busy_q && !xf_dir_q && !rx_ok;
      xf_widx_q <= BUF_AW'(xf_cnt_q);
    end
  end
  // Swap roles at each completed transfer
  logic xf_end;
  assign xf_end = xf_busy_q && !rx_ok && (xf_cnt_q == xf_len - 8'h01);
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ib_swap_q <= 1'b0;
      ob_swap_q <= 1'b0;
    end else if (xf_end) begin
      if (xf_dir_q) ib_swap_q <= ~ib_swap_q;
      else ob_swap_q <= ~ob_swap_q;
    end
  end
  // Message RAM port; receive has priority over host transfer
  always_comb begin
    mram_p.sel = 1'b0;
    mram_p.we = 1'b0;
    mram_p.addr = data_base + MRAM_AW'(xf_cnt_q);
    mram_p.wdata = ib_swap_q ? ib_p[1].rdata[31:0] : ib_p[0].rdata[31:0];
    if (rx_ok) begin
      mram_p.sel = 1'b1;
      mram_p.we = 1'b1;
      mram_p.addr = rx_ptr_q;
      mram_p.wdata = rxw_s2_q;
    end else if (wr_in && hit(addr_in, FRMH_REG_MDATA)) begin
      mram_p.sel = 1'b1;
      mram_p.we = 1'b1;
      mram_p.addr = mram_addr_q;
      mram_p.wdata = wdata_in;
    end else if (xf_busy_q) begin
      mram_p.sel = 1'b1;
      mram_p.we = xf_dir_q;
    end else if (rd_in && hit(addr_in, FRMH_REG_MDATA)) begin
      mram_p.sel = 1'b1;
      mram_p.addr = mram_addr_q;
    end
  end
  // Buffer RAM ports: one select per access, by role
  logic [1:0] ib_sel, ob_sel;
  assign test_acc = test_q && (wr_in || rd_in) && hit(addr_in, FRMH_REG_TDATA);
  generate
    for (g = 0; g < 2; g++) begin : g_port
      always_comb begin
        ib_sel[g] = 1'b0;
        ob_sel[g] = 1'b0;
        ib_p[g].we = 1'b0;
        ob_p[g].we = 1'b0;
        ib_p[g].addr = test_addr_q;
        ob_p[g].addr = test_addr_q;
        ib_p[g].wdata = wdata_in;
        ob_p[g].wdata = wdata_in;
        if (test_acc) begin
          ib_sel[g] = test_ram_q == {2'b00, 1'(g)};
          ob_sel[g] = test_ram_q == {2'b01, 1'(g)};
          ib_p[g].we = wr_in;
          ob_p[g].we = wr_in;
        end else if (xf_busy_q && xf_dir_q && (1'(g) == ib_swap_q)) begin
          ib_sel[g] = !rx_ok;
          ib_p[g].addr = BUF_AW'(xf_cnt_q);
        end else if (xf_rd_q && (1'(g) == ob_swap_q)) begin
          ob_sel[g] = 1'b1;
          ob_p[g].we = 1'b1;
          ob_p[g].addr = xf_widx_q;
          ob_p[g].wdata = mram_p.rdata[31:0];
        end else if (wr_in && hit(addr_in, FRMH_REG_TDATA) && (1'(g) == ib_swap_q)) begin
          ib_sel[g] = 1'b1;
          ib_p[g].we = 1'b1;
        end
        ib_p[g].sel = ib_sel[g];
        ob_p[g].sel = ob_sel[g];
      end
    end
  endgenerate
  // Parity check on every buffer read, one cycle after the select
  logic [1:0] ib_rd_q, ob_rd_q;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ib_rd_q <= '0;
      ob_rd_q <= '0;
    end else begin
      ib_rd_q <= {ib_sel[1] && !ib_p[1].we, ib_sel[0] && !ib_p[0].we};
      ob_rd_q <= {ob_sel[1] && !ob_p[1].we, ob_sel[0] && !ob_p[0].we};
    end
  end
  logic ib_perr, ob_perr;
  assign ib_perr = (ib_rd_q[0] && ^ib_p[0].rdata) || (ib_rd_q[1] && ^ib_p[1].rdata);
  assign ob_perr = (ob_rd_q[0] && ^ob_p[0].rdata) || (ob_rd_q[1] && ^ob_p[1].rdata);
  // Sticky events; set wins over write-one clear
  logic [FRMH_NIRQ-1:0] ev;
  assign ev = {tx_startup_out, xf_end, rx_done, ob_perr, ib_perr};
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) irq_st_q <= '0;
    else if (wr_in && hit(addr_in, FRMH_REG_IRQ))
      irq_st_q <= (irq_st_q & ~wdata_in[FRMH_NIRQ-1:0]) | ev;
    else irq_st_q <= irq_st_q | ev;
  end
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) irq_out <= 1'b0;
    else irq_out <= |(irq_st_q & mask_q);
  end
  // Configuration writes
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cfg_q <= FRMH_CFG_RESET;
      mask_q <= '0;
      test_q <= 1'b0;
      test_ram_q <= '0;
      test_addr_q <= '0;
      mram_addr_q <= '0;
    end else if (wr_in) begin
      if (hit(addr_in, FRMH_REG_CFG) && poc_q == FRMH_ST_CFG) cfg_q <= wdata_in;
      if (hit(addr_in, FRMH_REG_MASK)) mask_q <= wdata_in[FRMH_NIRQ-1:0];
      if (hit(addr_in, FRMH_REG_TEST)) begin
        test_q <= wdata_in[31];
        test_ram_q <= wdata_in[18:16];
        test_addr_q <= wdata_in[BUF_AW-1:0];
      end
      if (hit(addr_in, FRMH_REG_MRAM)) mram_addr_q <= wdata_in[MRAM_AW-1:0];
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) test_sel_out <= '0;
    else test_sel_out <= {|ob_sel, |ib_sel};
  end
  // Read data one cycle after strobe
  logic rd_q;
  logic [7:0] rd_addr_q;
  logic [31:0] rd_mux;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rd_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rd_q <= rd_in;
      rd_addr_q <= addr_in;
    end
  end
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rd_addr_q)
      FRMH_REG_CFG: rd_mux = cfg_q;
      FRMH_REG_STAT: rd_mux = {25'h0, ob_swap_q, ib_swap_q, xf_busy_q, 1'b0, poc_q};
      FRMH_REG_IRQ: rd_mux = {27'h0, irq_st_q};
      FRMH_REG_MASK: rd_mux = {27'h0, mask_q};
      FRMH_REG_TEST: rd_mux = {test_q, 12'h0, test_ram_q, 16'(test_addr_q)};
      FRMH_REG_TDATA: rd_mux = test_ram_q[0] ?
          (test_ram_q[1] ? ob_p[1].rdata[31:0] : ib_p[1].rdata[31:0]) :
          (test_ram_q[1] ? ob_p[0].rdata[31:0] : ib_p[0].rdata[31:0]);
      FRMH_REG_MDATA: rd_mux = mram_p.rdata[31:0];
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // RAM words finish in the RAM's own register, so this last mux stays unregistered
  always_comb rdata_out = rd_q ? rd_mux : 32'h0000_0000;
  a_startup_pulse: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (poc_q == FRMH_ST_COLD && !tx_startup_out) |=> tx_startup_out)
    else $error("start-up frame not sent");
  a_ib_one_sel: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !(ib_sel[0] && ib_sel[1]))
    else $error("both input RAMs selected");
  a_ob_one_sel: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !(ob_sel[0] && ob_sel[1]))
    else $error("both output RAMs selected");
  a_ib_par_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ib_perr |=> irq_st_q[FRMH_ST_PIBF])
    else $error("input parity flag missed");
  a_ob_par_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ob_perr |=> irq_st_q[FRMH_ST_POBF])
    else $error("output parity flag missed");
  a_ob_word0_kept: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ($fell(xf_busy_q) && !xf_dir_q) |=> ##1 !(|ob_sel) || test_q)
    else $error("output buffer written after transfer");
  a_xfer_no_over: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (mram_p.we && xf_busy_q && !rx_ok) |-> xf_cnt_q < xf_len)
    else $error("write beyond data section");
  a_swap_toggle: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (xf_end && xf_dir_q) |=> ib_swap_q != $past(ib_swap_q))
    else $error("input swap missed");
  a_loop_store: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (poc_q == FRMH_ST_LOOPB && brp == FRMH_BRP_FAST && rxv_s2_q) |-> mram_p.we)
    else $error("loop-back frame not stored");
  c_loopback: cover property (@(posedge sys_clk_in) poc_q == FRMH_ST_LOOPB && rx_done);
  c_coldstart: cover property (@(posedge sys_clk_in) tx_startup_out);
  c_xfer_out: cover property (@(posedge sys_clk_in) xf_end && !xf_dir_q);
  c_test_par: cover property (@(posedge sys_clk_in) ib_perr);
endmodule // frmh_core

// file: logic/frmh_pkg.sv
package frmh_pkg;
  localparam logic [7:0] FRMH_REG_CMD = 8'h00;
  localparam logic [7:0] FRMH_REG_CFG = 8'h04;
  localparam logic [7:0] FRMH_REG_STAT = 8'h08;
  localparam logic [7:0] FRMH_REG_IRQ = 8'h0C;
  localparam logic [7:0] FRMH_REG_MASK = 8'h10;
  localparam logic [7:0] FRMH_REG_XFER = 8'h14;
  localparam logic [7:0] FRMH_REG_TEST = 8'h18;
  localparam logic [7:0] FRMH_REG_TDATA = 8'h1C;
  localparam logic [7:0] FRMH_REG_MRAM = 8'h20;
  localparam logic [7:0] FRMH_REG_MDATA = 8'h24;
  // Command codes
  localparam logic [3:0] FRMH_CMD_CONFIG = 4'h1;
  localparam logic [3:0] FRMH_CMD_READY = 4'h2;
  localparam logic [3:0] FRMH_CMD_RUN = 4'h3;
  localparam logic [3:0] FRMH_CMD_HALT = 4'h4;
  localparam logic [3:0] FRMH_CMD_FREEZE = 4'h5;
  localparam logic [3:0] FRMH_CMD_LOOP = 4'h6;
  localparam logic [3:0] FRMH_CMD_COLD = 4'h7;
  // Config field positions
  localparam int FRMH_CFG_LCB_LSB = 0;
  localparam int FRMH_CFG_BRP_LSB = 8;
  localparam int FRMH_CFG_SLOT_LSB = 12;
  localparam int FRMH_CFG_PLC_LSB = 16;
  localparam logic [31:0] FRMH_CFG_RESET = 32'h0000_0000;
  localparam logic [1:0] FRMH_BRP_FAST = 2'h0;
  // Status / interrupt bits
  localparam int FRMH_ST_PIBF = 0;
  localparam int FRMH_ST_POBF = 1;
  localparam int FRMH_ST_RXST = 2;
  localparam int FRMH_ST_XFER = 3;
  localparam int FRMH_ST_SUF = 4;
  localparam int FRMH_NIRQ = 5;
  localparam logic [6:0] FRMH_PLC_MAX = 7'h7F;
  localparam int FRMH_ADDR_W = 8;
  localparam int FRMH_MRAM_W = 9;
  typedef enum logic [2:0] {
    FRMH_ST_DEFCFG = 3'b000,
    FRMH_ST_CFG = 3'b001,
    FRMH_ST_READY = 3'b010,
    FRMH_ST_NORMAL = 3'b011,
    FRMH_ST_HALT = 3'b100,
    FRMH_ST_LOOPB = 3'b101,
    FRMH_ST_COLD = 3'b110
  } frmh_poc_t;
endpackage

// file: logic/frmh_ram.sv
`timescale 1ns/1ps
module frmh_ram #(
  parameter int AW = 9
) (
  input wire logic sys_clk_in,
  frmh_ram_if.ram port
);
  // Word plus even parity bit; read data registered
  logic [32:0] mem [0:(1<<AW)-1];
  logic [32:0] rdata_q;
  if (AW < 2 || AW > 12) begin : g_chk_aw
    $error("frmh_ram: AW out of range");
  end
  always_ff @(posedge sys_clk_in) begin
    if (port.sel && port.we) begin
      mem[port.addr] <= {^port.wdata, port.wdata};
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (port.sel && !port.we) begin
      rdata_q <= mem[port.addr];
    end
  end
  assign port.rdata = rdata_q;
endmodule // frmh_ram

// file: logic/frmh_ram_if.sv
`timescale 1ns/1ps
interface frmh_ram_if #(parameter int AW = 9);
  logic sel;
  logic we;
  logic [AW-1:0] addr;
  logic [31:0] wdata;
  logic [32:0] rdata;
  modport ctl (output sel, output we, output addr, output wdata, input rdata);
  modport ram (input sel, input we, input addr, input wdata, output rdata);
endinterface

// file: tb/frmh_chan_model.sv
`timescale 1ns/1ps
module frmh_chan_model (
  input wire logic sys_clk_in,
  output logic rx_valid_out,
  output logic [31:0] rx_word_out,
  output logic rx_last_out
);
  initial begin
    rx_valid_out = 1'b0;
    rx_word_out = 32'h5A5A_5A5A;
    rx_last_out = 1'b0;
  end
  // One word a cycle; between frames the data line flips so a stale word never looks valid
  task automatic send_frame(input logic [31:0] first, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_in);
      rx_valid_out <= 1'b1;
      rx_word_out <= first + 32'(i);
      rx_last_out <= (i == n - 1);
    end
    @(posedge sys_clk_in);
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    rx_word_out <= ~rx_word_out;
  endtask
endmodule // frmh_chan_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import frmh_pkg::*;
  logic clk, rst, wr_s, rd_s, rxv, rxl, tx_su, irq;
  logic [7:0] addr;
  logic [31:0] wd, rdat, rxw, rv, v2;
  logic [1:0] tsel, sel_seen;
  logic [2:0] rams [4] = '{3'h1, 3'h2, 3'h0, 3'h3};
  int miscompares = 0;
  int n_compared = 0;
  int n_start = 0;
  frmh_core u_frmh_core (.sys_clk_in(clk), .reset_in(rst), .addr_in(addr), .wdata_in(wd),
    .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdat), .rx_valid_in(rxv), .rx_word_in(rxw),
    .rx_last_in(rxl), .tx_startup_out(tx_su), .test_sel_out(tsel), .irq_out(irq));
  frmh_chan_model u_frmh_chan_model (.sys_clk_in(clk), .rx_valid_out(rxv),
    .rx_word_out(rxw), .rx_last_out(rxl));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (tx_su === 1'b1) n_start++;
    sel_seen = sel_seen | tsel;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 rv = rdat;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    rd(a);
    check(nm, rv & m, exp);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [2:0] st);
    wr(FRMH_REG_CMD, {28'h0, c});
    rchk("state", FRMH_REG_STAT, 32'h7, {29'h0, st});
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] brp, input logic [6:0] payload_length_setting);
    // Last buffer 3 puts the data partition at word 8; start-up slot 1 is the hazardous range
    return {9'h000, payload_length_setting, 4'h1, 2'h0, brp, 8'h03};
  endfunction
  task automatic cold();
    int n0;
    n0 = n_start;
    wr(FRMH_REG_CMD, {28'h0, FRMH_CMD_COLD});
    repeat (4) @(posedge clk);
    #1 check("startup pulses", 32'(n_start - n0), 32'h1);
    rchk("state", FRMH_REG_STAT, 32'h7, 32'h3);
  endtask
  task automatic xfer(input logic [31:0] dir);
    wr(FRMH_REG_XFER, dir);
    for (int i = 0; i < 300; i++) begin
      rd(FRMH_REG_STAT);
      if (rv[4] === 1'b0) break;
    end
    check("busy", rv & 32'h10, 32'h0);
  endtask
  task automatic reset_dut();
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wd = 32'h0;
    sel_seen = 2'h0;
    reset_dut();
    rchk("stat reset", FRMH_REG_STAT, 32'hFFFFFFFF, 32'h0);
    rchk("irq reset", FRMH_REG_IRQ, 32'hFFFFFFFF, 32'h0);
    rchk("mask reset", FRMH_REG_MASK, 32'hFFFFFFFF, 32'h0);
    rchk("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    cmd(FRMH_CMD_CONFIG, 3'h1);
    wr(FRMH_REG_CFG, cfg(2'h0, 7'h07));
    rchk("cfg", FRMH_REG_CFG, 32'hFFFFFFFF, cfg(2'h0, 7'h07));
    cmd(FRMH_CMD_READY, 3'h2);
    cold();
    // Restart after freeze and after ready, the cases where the start-up frame can go missing
    cmd(FRMH_CMD_FREEZE, 3'h4);
    cmd(FRMH_CMD_CONFIG, 3'h1);
    cmd(FRMH_CMD_READY, 3'h2);
    cold();
    cmd(FRMH_CMD_READY, 3'h2);
    cold();
    cmd(FRMH_CMD_FREEZE, 3'h4);
    cmd(FRMH_CMD_CONFIG, 3'h1);
    wr(FRMH_REG_CFG, cfg(2'h0, 7'h07) | 32'h8000);
    cmd(FRMH_CMD_READY, 3'h2);
    cold();
    $display("test coldstart done");
    check("irq idle", {31'h0, irq}, 32'h0);
    wr(FRMH_REG_MASK, 32'h10);
    repeat (2) @(posedge clk);
    #1 check("irq on", {31'h0, irq}, 32'h1);
    wr(FRMH_REG_IRQ, 32'h10);
    repeat (2) @(posedge clk);
    #1 check("irq off", {31'h0, irq}, 32'h0);
    rchk("irq clr", FRMH_REG_IRQ, 32'h10, 32'h0);
    $display("test interrupt done");
    cmd(FRMH_CMD_HALT, 3'h4);
    cmd(FRMH_CMD_CONFIG, 3'h1);
    cmd(FRMH_CMD_LOOP, 3'h5);
    u_frmh_chan_model.send_frame(32'hA500_0000, 3);
    repeat (20) @(posedge clk);
    rchk("loop rx", FRMH_REG_IRQ, 32'h4, 32'h4);
    wr(FRMH_REG_MRAM, 32'h8);
    rchk("rx word", FRMH_REG_MDATA, 32'hFFFFFFFF, 32'hA500_0000);
    $display("test loopback done");
    reset_dut();
    // Second input RAM before the first, first output RAM before the second: an extra select would read an unwritten word
    for (int i = 0; i < 4; i++) begin
      wr(FRMH_REG_TEST, {1'b1, 12'h0, rams[i], 10'h0, 6'h05});
      sel_seen = 2'h0;
      wr(FRMH_REG_TDATA, 32'hC0DE_0000 | 32'(i));
      rchk("test word", FRMH_REG_TDATA, 32'hFFFFFFFF, 32'hC0DE_0000 | 32'(i));
      check("ram select", {30'h0, sel_seen}, rams[i][1] ? 32'h2 : 32'h1);
    end
    rchk("parity", FRMH_REG_IRQ, 32'h3, 32'h0);
    wr(FRMH_REG_TEST, 32'h0);
    $display("test ram mode done");
    cmd(FRMH_CMD_CONFIG, 3'h1);
    wr(FRMH_REG_CFG, cfg(2'h1, 7'h07));
    wr(FRMH_REG_MRAM, 32'hC);
    wr(FRMH_REG_MDATA, 32'h5E5E_0C0C);
    xfer(32'h1);
    wr(FRMH_REG_MRAM, 32'hC);
    rchk("next section", FRMH_REG_MDATA, 32'hFFFFFFFF, 32'h5E5E_0C0C);
    rchk("xfer end", FRMH_REG_IRQ, 32'h8, 32'h8);
    rchk("ib swap", FRMH_REG_STAT, 32'h20, 32'h20);
    wr(FRMH_REG_CFG, cfg(2'h1, FRMH_PLC_MAX));
    wr(FRMH_REG_MRAM, 32'h8);
    wr(FRMH_REG_MDATA, 32'h1234_ABCD);
    xfer(32'h0);
    rchk("ob swap", FRMH_REG_STAT, 32'h40, 32'h40);
    wr(FRMH_REG_TEST, {1'b1, 12'h0, 3'h2, 16'h0});
    rd(FRMH_REG_TDATA);
    v2 = rv;
    wr(FRMH_REG_TEST, {1'b1, 12'h0, 3'h3, 16'h0});
    rd(FRMH_REG_TDATA);
    check("ob word 0", {31'h0, v2 === 32'h1234_ABCD || rv === 32'h1234_ABCD}, 32'h1);
    wr(FRMH_REG_TEST, 32'h0);
    $display("test transfer done");
    cmd(FRMH_CMD_LOOP, 3'h5);
    u_frmh_chan_model.send_frame(32'hB600_0000, 2);
    repeat (20) @(posedge clk);
    rchk("slow loop", FRMH_REG_IRQ, 32'h4, 32'h0);
    $display("test prescaler done");
    finish_test();
  end
endmodule // testbench
